// *** inc/sdcs_cfg.svh ***
`ifndef SDCS_CFG_SVH
`define SDCS_CFG_SVH
`define SDCS_OFF_CTRL 5'h00
`define SDCS_OFF_STAT 5'h04
`define SDCS_OFF_MR 5'h08
`define SDCS_OFF_EMR 5'h0C
`define SDCS_OFF_REF 5'h10
`define SDCS_CTRL_RST 2'h1
`define SDCS_CTRL_EN 0
`define SDCS_CTRL_CLR 1
`define SDCS_CLK_NS 100
`define SDCS_TRP_NS 20
`define SDCS_TRP_CYC ((`SDCS_TRP_NS + `SDCS_CLK_NS - 1) / `SDCS_CLK_NS)
`define SDCS_AP_BIT 10
`define SDCS_BL_LSB 0
`define SDCS_BL8 3'h3
`define SDCS_AL_LSB 3
`define SDCS_RTT_LO 2
`define SDCS_RTT_HI 6
`define SDCS_AL_MAX 7
`endif

// *** inc/sdcs_pkg.sv ***
package sdcs_pkg;
	typedef enum logic [3:0] {
		C_DESEL, C_NOP, C_MRS, C_REF, C_SREF, C_PRE, C_ACT, C_WR, C_RD, C_PDN, C_ILL
	} sdcs_cmd_e;
	typedef enum logic [1:0] {
		M_RUN = 2'b00,
		M_PDN = 2'b01,
		M_SREF = 2'b11
	} sdcs_mode_e;
	typedef struct packed {
		logic ck;
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic die_termination_ctl;
		logic [1:0] ba;
		logic [12:0] addr;
		logic [15:0] dq;
		logic [1:0] dm;
	} sdcs_pins_s;
	typedef struct packed {
		logic vld;
		logic wr;
		logic ap;
		logic [1:0] ba;
		logic [8:0] col;
	} sdcs_post_s;
endpackage : sdcs_pkg

// *** logic/sdcs_core.sv ***
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/100ps
`include "sdcs_cfg.svh"
module sdcs_core #(
	parameter int MCOL_W = 4
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_clk_en,
	input wire logic i_ck,
	input wire logic i_cke,
	input wire logic i_cs_n,
	input wire logic i_ras_n,
	input wire logic i_cas_n,
	input wire logic i_we_n,
	input wire logic i_odt,
	input wire logic [1:0] i_ba,
	input wire logic [12:0] i_addr,
	input wire logic [15:0] i_dq,
	input wire logic [1:0] i_dm,
	output logic [15:0] o_dq,
	output logic o_dq_oe,
	output logic o_odt_on,
	output logic o_dll_on,
	output logic o_self_refresh,
	input wire logic [4:0] i_av_address,
	input wire logic i_av_read,
	input wire logic i_av_write,
	input wire logic [31:0] i_av_writedata,
	input wire logic [3:0] i_av_byteenable,
	output logic [31:0] o_av_readdata,
	output logic o_av_waitrequest
);
	localparam int IW = 2 + MCOL_W;
	localparam logic [2:0] PRECHARGE_PERIOD = 3'(`SDCS_TRP_CYC);
	// ----------------------------------------
	// pin synchronisers and link clock edge
	// ----------------------------------------
	sdcs_pkg::sdcs_pins_s raw, s1_r, pin;
	logic ck_d_r, rise, cke_prev_r;
	assign raw = '{i_ck, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_odt, i_ba, i_addr, i_dq, i_dm};
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			s1_r <= '{ck: 1'b1, default: '0};
			pin <= '{ck: 1'b1, default: '0};
			ck_d_r <= 1'b1;
		end else if (i_clk_en) begin
			s1_r <= raw;
			pin <= s1_r;
			ck_d_r <= pin.ck;
		end
	end
	assign rise = pin.ck & ~ck_d_r;
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset)
			cke_prev_r <= 1'b0;
		else if (i_clk_en && rise)
			cke_prev_r <= pin.cke;
	end
	// ----------------------------------------
	// command decode
	// ----------------------------------------
	function automatic sdcs_pkg::sdcs_cmd_e decode(input sdcs_pkg::sdcs_pins_s p);
		if (!p.cke)
			return (!p.cs_n && !p.ras_n && !p.cas_n && p.we_n) ? sdcs_pkg::C_SREF
				: sdcs_pkg::C_PDN;
		if (p.cs_n)
			return sdcs_pkg::C_DESEL;
		unique case ({p.ras_n, p.cas_n, p.we_n})
			3'h7: return sdcs_pkg::C_NOP;
			3'h0: return sdcs_pkg::C_MRS;
			3'h1: return sdcs_pkg::C_REF;
			3'h2: return sdcs_pkg::C_PRE;
			3'h3: return sdcs_pkg::C_ACT;
			3'h4: return sdcs_pkg::C_WR;
			3'h5: return sdcs_pkg::C_RD;
			default: return sdcs_pkg::C_ILL;
		endcase
	endfunction : decode
	sdcs_pkg::sdcs_mode_e mode_r;
	sdcs_pkg::sdcs_cmd_e cmd;
	logic [1:0] ctrl_r;
	logic go;
	assign cmd = decode(pin);
	// commands only on a link rise, awake, with clock enable held high before
	assign go = rise & cke_prev_r & (mode_r == sdcs_pkg::M_RUN) & ctrl_r[`SDCS_CTRL_EN];
	// ----------------------------------------
	// power modes and delay lock loop
	// ----------------------------------------
	logic dll_r;
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			mode_r <= sdcs_pkg::M_RUN;
			dll_r <= 1'b1;
		end else if (i_clk_en) begin
			unique case (mode_r)
				sdcs_pkg::M_RUN: begin
					if (go && cmd == sdcs_pkg::C_SREF) begin
						mode_r <= sdcs_pkg::M_SREF;
						dll_r <= 1'b0;
					end else if (go && cmd == sdcs_pkg::C_PDN)
						mode_r <= sdcs_pkg::M_PDN;
				end
				sdcs_pkg::M_PDN: begin
					if (rise && pin.cke)
						mode_r <= sdcs_pkg::M_RUN;
				end
				sdcs_pkg::M_SREF: begin
					// exit needs no link edge: the clock may be stopped here
					if (pin.cke) begin
						mode_r <= sdcs_pkg::M_RUN;
						dll_r <= 1'b1;
					end
				end
				default: mode_r <= sdcs_pkg::M_RUN;
			endcase
		end
	end
	// ----------------------------------------
	// mode registers, refresh counter, termination
	// ----------------------------------------
	logic [12:0] mr_r, emr_r, ref_row_r;
	logic odt_r;
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			mr_r <= '0;
			emr_r <= '0;
		end else if (i_clk_en && go && cmd == sdcs_pkg::C_MRS) begin
			if (pin.ba == 2'h0)
				mr_r <= pin.addr;
			else if (pin.ba == 2'h1)
				emr_r <= pin.addr;
		end
	end
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset)
			ref_row_r <= '0;
		else if (i_clk_en && go && (cmd == sdcs_pkg::C_REF || cmd == sdcs_pkg::C_SREF))
			ref_row_r <= ref_row_r + 13'h0001;
	end
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset)
			odt_r <= 1'b0;
		else if (i_clk_en)
			odt_r <= (emr_r[`SDCS_RTT_LO] | emr_r[`SDCS_RTT_HI]) & pin.die_termination_ctl
				& (mode_r != sdcs_pkg::M_SREF);
	end
	// ----------------------------------------
	// posted commands and bursts
	// ----------------------------------------
	sdcs_pkg::sdcs_post_s newc, launch, bst_r;
	sdcs_pkg::sdcs_post_s pipe_r [`SDCS_AL_MAX];
	logic [2:0] al;
	logic [3:0] bl, cnt_r;
	logic beat, last;
	assign al = emr_r[`SDCS_AL_LSB +: 3];
	assign bl = (mr_r[`SDCS_BL_LSB +: 3] == `SDCS_BL8) ? 4'h8 : 4'h4;
	assign newc = '{go && (cmd == sdcs_pkg::C_WR || cmd == sdcs_pkg::C_RD),
		cmd == sdcs_pkg::C_WR, pin.addr[`SDCS_AP_BIT], pin.ba, pin.addr[8:0]};
	assign launch = (al == 3'h0) ? newc : pipe_r[al - 3'h1];
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset)
			pipe_r[0] <= '0;
		else if (i_clk_en && rise)
			pipe_r[0] <= newc;
	end
	for (genvar g = 1; g < `SDCS_AL_MAX; g++) begin : g_post
		always_ff @(posedge i_clock or posedge i_reset) begin
			if (i_reset)
				pipe_r[g] <= '0;
			else if (i_clk_en && rise)
				pipe_r[g] <= pipe_r[g - 1];
		end
	end
	assign beat = rise & (cnt_r != 4'h0);
	assign last = beat & (cnt_r == 4'h1);
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			cnt_r <= 4'h0;
			bst_r <= '0;
		end else if (i_clk_en && rise) begin
			if (launch.vld) begin
				cnt_r <= bl;
				bst_r <= launch;
			end else if (cnt_r != 4'h0)
				cnt_r <= cnt_r - 4'h1;
		end
	end
	// ----------------------------------------
	// array and data path
	// ----------------------------------------
	logic [15:0] mem [2 ** IW];
	logic [8:0] col;
	logic [IW-1:0] idx;
	logic [15:0] old;
	logic [15:0] dq_r;
	logic oe_r;
	assign col = bst_r.col + 9'(bl - cnt_r);
	assign idx = {bst_r.ba, col[MCOL_W-1:0]};
	assign old = mem[idx];
	always_ff @(posedge i_clock) begin
		if (i_clk_en && beat && bst_r.wr) begin
			for (int b = 0; b < 2; b++) begin
				if (!pin.dm[b])
					mem[idx][8*b +: 8] <= pin.dq[8*b +: 8];
			end
		end
	end
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			dq_r <= '0;
			oe_r <= 1'b0;
		end else if (i_clk_en && rise) begin
			oe_r <= beat & ~bst_r.wr;
			dq_r <= (beat && !bst_r.wr) ? old : 16'h0000;
		end
	end
	// ----------------------------------------
	// bank state and precharge timing
	// ----------------------------------------
	logic [3:0] pre_v, act_v, open_r, busy;
	logic [2:0] pcnt_r [4];
	logic [12:0] row_r [4];
	logic refused;
	always_comb begin
		pre_v = 4'h0;
		act_v = 4'h0;
		if (go && cmd == sdcs_pkg::C_PRE)
			pre_v = pin.addr[`SDCS_AP_BIT] ? 4'hF : 4'(1 << pin.ba);
		if (go && cmd == sdcs_pkg::C_ACT)
			act_v = 4'(1 << pin.ba);
		if (last && bst_r.ap)
			pre_v[bst_r.ba] = 1'b1;
	end
	// an activate during the precharge period or onto an open row is refused
	assign refused = |(act_v & (busy | open_r));
	for (genvar g = 0; g < 4; g++) begin : g_bank
		assign busy[g] = pcnt_r[g] != 3'h0;
		always_ff @(posedge i_clock or posedge i_reset) begin
			if (i_reset) begin
				open_r[g] <= 1'b0;
				pcnt_r[g] <= 3'h0;
				row_r[g] <= '0;
			end else if (i_clk_en) begin
				if (pre_v[g]) begin
					open_r[g] <= 1'b0;
					pcnt_r[g] <= PRECHARGE_PERIOD;
				end else if (act_v[g] && !busy[g] && !open_r[g]) begin
					open_r[g] <= 1'b1;
					row_r[g] <= pin.addr;
				end else if (busy[g])
					pcnt_r[g] <= pcnt_r[g] - 3'h1;
			end
		end
	end
	// ----------------------------------------
	// register slave
	// ----------------------------------------
	logic ack_r, err_r, req;
	logic [31:0] rd;
	assign req = i_av_read | i_av_write;
	assign o_av_waitrequest = req & ~ack_r;
	always_comb begin
		unique case (i_av_address)
			`SDCS_OFF_CTRL: rd = {30'h0, ctrl_r};
			`SDCS_OFF_STAT: rd = {20'h0, err_r, dll_r, mode_r, busy, open_r};
			`SDCS_OFF_MR: rd = {19'h0, mr_r};
			`SDCS_OFF_EMR: rd = {19'h0, emr_r};
			`SDCS_OFF_REF: rd = {19'h0, ref_row_r};
			default: rd = 32'h0;
		endcase
	end
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			ack_r <= 1'b0;
			o_av_readdata <= '0;
		end else if (i_clk_en) begin
			ack_r <= req & ~ack_r;
			if (i_av_read && !ack_r)
				o_av_readdata <= rd;
		end
	end
	logic wr_ctrl;
	assign wr_ctrl = i_av_write & ack_r & i_av_byteenable[0] & (i_av_address == `SDCS_OFF_CTRL);
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			ctrl_r <= `SDCS_CTRL_RST;
			err_r <= 1'b0;
		end else if (i_clk_en) begin
			if (wr_ctrl)
				ctrl_r[`SDCS_CTRL_EN] <= i_av_writedata[`SDCS_CTRL_EN];
			// a refusal in the clearing cycle keeps the flag set
			if (refused)
				err_r <= 1'b1;
			else if (wr_ctrl && i_av_writedata[`SDCS_CTRL_CLR])
				err_r <= 1'b0;
		end
	end
	assign o_dq = dq_r;
	assign o_dq_oe = oe_r;
	assign o_odt_on = odt_r;
	assign o_dll_on = dll_r;
	assign o_self_refresh = mode_r == sdcs_pkg::M_SREF;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);
	desel_no_load_a: assert property (i_clk_en && go && cmd == sdcs_pkg::C_DESEL
		|=> $stable(mr_r) && $stable(emr_r) && $stable(ref_row_r))
		else $error("deselect changed state");
	nop_burst_runs_a: assert property (i_clk_en && go && cmd == sdcs_pkg::C_NOP
		&& cnt_r > 4'h1 && !launch.vld |=> cnt_r == $past(cnt_r) - 4'h1)
		else $error("nop disturbed burst");
	mode_load_a: assert property (i_clk_en && go && cmd == sdcs_pkg::C_MRS
		&& pin.ba == 2'h0 |=> mr_r == $past(pin.addr))
		else $error("mode register not loaded");
	act_opens_a: assert property (i_clk_en && act_v != 4'h0 && !refused
		&& pre_v == 4'h0 |=> (open_r & $past(act_v)) == $past(act_v))
		else $error("activate did not open bank");
	burst_start_a: assert property (i_clk_en && rise && launch.vld
		|=> cnt_r == bl && bst_r.wr == $past(launch.wr))
		else $error("burst did not start");
	auto_pre_a: assert property (i_clk_en && last && bst_r.ap
		|=> !open_r[$past(bst_r.ba)] && busy[$past(bst_r.ba)])
		else $error("auto precharge missing");
	mask_keep_a: assert property (i_clk_en && beat && bst_r.wr && pin.dm[0]
		|=> mem[$past(idx)][7:0] == $past(old[7:0]))
		else $error("masked byte written");
	pre_timer_a: assert property (i_clk_en && pre_v != 4'h0
		|=> (busy & $past(pre_v)) == $past(pre_v) && (open_r & $past(pre_v)) == 4'h0)
		else $error("precharge period not started");
	ref_count_a: assert property (i_clk_en && go && cmd == sdcs_pkg::C_REF
		|=> ref_row_r == $past(ref_row_r) + 13'h0001)
		else $error("refresh counter not advanced");
	sref_dll_a: assert property (o_self_refresh == !dll_r)
		else $error("dll not tracking self refresh");
	sref_odt_a: assert property (i_clk_en && o_self_refresh |=> !odt_r)
		else $error("termination in self refresh");
	read_burst_c: cover property (rise && launch.vld && !launch.wr);
	write_mask_c: cover property (beat && bst_r.wr && pin.dm != 2'h0);
	sref_cycle_c: cover property (o_self_refresh ##[1:1000] !o_self_refresh);
	posted_c: cover property (go && newc.vld && al != 3'h0);
endmodule : sdcs_core

// *** verification/sdcs_ctrl_model.sv ***
`timescale 1ns/100ps
// ----------------
// controller stand-in
// ----------------
// one command per link clock; the link clock stands high between frames
module sdcs_ctrl_model (
	input wire logic i_clock,
	input wire logic [15:0] i_dq,
	input wire logic i_dq_oe,
	output sdcs_pkg::sdcs_pins_s o_pins
);
	initial begin
		o_pins = '0;
		o_pins.ck = 1'b1;
		o_pins.cke = 1'b1;
		o_pins.cs_n = 1'b1;
	end
	// c is {cke, cs_n, ras_n, cas_n, we_n}; pins settle half a link clock before the rise
	task automatic cmd(input logic [4:0] c, input logic [1:0] ba, input logic [12:0] a,
		input logic [15:0] d, input logic [1:0] m, output logic oe, output logic [15:0] q);
		o_pins <= {1'b0, c, 1'b0, ba, a, d, m};
		repeat (4) @(posedge i_clock);
		oe = i_dq_oe;
		q = i_dq;
		o_pins.ck <= 1'b1;
		repeat (4) @(posedge i_clock);
	endtask : cmd
	// clock enable alone with no clock; data lines stop showing the last value
	task automatic idle(input logic cke);
		o_pins.cke <= cke;
		o_pins.dq <= ~o_pins.dq;
	endtask : idle
endmodule : sdcs_ctrl_model

// *** verification/sdcs_core_bench.sv ***
`timescale 1ns/100ps
module sdcs_core_bench;
	localparam logic [4:0] c_nop = 5'h17;
	localparam logic [4:0] c_des = 5'h1C;
	localparam logic [4:0] c_mrs = 5'h10;
	localparam logic [4:0] c_ref = 5'h11;
	localparam logic [4:0] c_pre = 5'h12;
	localparam logic [4:0] c_act = 5'h13;
	localparam logic [4:0] c_wr = 5'h14;
	localparam logic [4:0] c_rd = 5'h15;
	localparam logic [4:0] c_sre = 5'h01;
	localparam logic [4:0] c_pdn = 5'h07;
	logic i_clock, i_reset, die_termination_ctl, av_rd, av_wr, oe, dq_oe, odt_on, dll_on, sref, wait_r;
	logic [4:0] av_addr;
	logic [31:0] av_wd, av_q, rdata, v;
	logic [15:0] dq_o, q;
	logic [15:0] exp_mem [8];
	logic [1:0] b;
	logic [8:0] col;
	sdcs_pkg::sdcs_pins_s pins;
	int num_errors = 0;
	int checks = 0;
	int al = 0;
	int beats = 4;

	sdcs_ctrl_model mdl (.i_clock(i_clock), .i_dq(dq_o), .i_dq_oe(dq_oe), .o_pins(pins));
	sdcs_core uut (.i_clock(i_clock), .i_reset(i_reset), .i_clk_en(1'b1), .i_ck(pins.ck),
		.i_cke(pins.cke), .i_cs_n(pins.cs_n), .i_ras_n(pins.ras_n), .i_cas_n(pins.cas_n),
		.i_we_n(pins.we_n), .i_odt(die_termination_ctl), .i_ba(pins.ba), .i_addr(pins.addr), .i_dq(pins.dq),
		.i_dm(pins.dm), .o_dq(dq_o), .o_dq_oe(dq_oe), .o_odt_on(odt_on), .o_dll_on(dll_on),
		.o_self_refresh(sref), .i_av_address(av_addr), .i_av_read(av_rd), .i_av_write(av_wr),
		.i_av_writedata(av_wd), .i_av_byteenable(4'hF), .o_av_readdata(av_q),
		.o_av_waitrequest(wait_r));

	// ----------------
	// shared tasks
	// ----------------
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
		av_addr <= a;
		av_wd <= d;
		av_wr <= wr;
		av_rd <= ~wr;
		// only the watchdog ends a wait that never gets its answer
		do begin
			@(posedge i_clock);
		end while (wait_r !== 1'b0);
		rdata = av_q;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
		@(posedge i_clock);
	endtask : av
	task automatic go(logic [4:0] c, logic [1:0] ba, logic [12:0] a, logic [15:0] d,
		logic [1:0] m);
		mdl.cmd(c, ba, a, d, m, oe, q);
	endtask : go
	task automatic nop(int n);
		repeat (n) go(c_nop, '0, '0, 16'($urandom), '0);
	endtask : nop
	function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] d, logic [1:0] m);
		return {m[1] ? o[15:8] : d[15:8], m[0] ? o[7:0] : d[7:0]};
	endfunction : merge
	task automatic wr_burst(logic full);
		logic [15:0] d;
		logic [1:0] m;
		go(c_wr, b, {4'h0, col}, 16'($urandom), '0);
		nop(al);
		for (int k = 0; k < beats; k++) begin
			d = 16'($urandom);
			m = full ? 2'h0 : 2'($urandom);
			go(c_nop, '0, '0, d, m);
			exp_mem[k] = full ? d : merge(exp_mem[k], d, m);
		end
	endtask : wr_burst
	task automatic status(string nm, logic [31:0] e);
		av(1'b0, 5'h04, '0);
		chk(nm, e, rdata & 32'h80F);
	endtask : status

	// ----------------
	// main sequence
	// ----------------
	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	initial begin
		#2000000;
		num_errors++;
		print_verdict();
	end
	initial begin
		i_reset = 1'b1;
		die_termination_ctl = 1'b0;
		av_rd = 1'b0;
		av_wr = 1'b0;
		av_addr = '0;
		av_wd = '0;
		v = $urandom(32'hE5349BDD);
		repeat (12) @(posedge i_clock);
		chk("dll_reset", 1, dll_on);
		chk("sref_reset", 0, sref);
		chk("odt_reset", 0, odt_on);
		i_reset <= 1'b0;
		nop(1);
		av(1'b0, 5'h08, '0);
		chk("mr_reset", 0, rdata);
		av(1'b0, 5'h00, '0);
		chk("ctrl_reset", 1, rdata);
		av(1'b1, 5'h14, 32'hFFFFFFFF);
		av(1'b0, 5'h14, '0);
		chk("unmapped", 0, rdata);
		$display("done: registers");
		v = ($urandom & 32'h1FF8) | 32'h2;
		go(c_mrs, 2'h0, v[12:0], 16'($urandom), '0);
		nop(2);
		av(1'b0, 5'h08, '0);
		chk("mr_load", v, rdata);
		go(c_mrs, 2'h1, 13'h0004, 16'($urandom), '0);
		nop(2);
		av(1'b0, 5'h0C, '0);
		chk("emr_load", 32'h4, rdata);
		die_termination_ctl <= 1'b1;
		nop(1);
		chk("odt_on", 1, odt_on);
		$display("done: mode load");
		for (int i = 0; i < 3; i++) begin
			b = 2'($urandom);
			col = 9'($urandom);
			al = 2 - i;
			beats = (i == 0) ? 8 : 4;
			go(c_mrs, 2'h0, (i == 0) ? 13'h0003 : 13'h0002, 16'($urandom), '0);
			nop(2);
			go(c_mrs, 2'h1, {7'h0, 3'(al), 3'h4}, 16'($urandom), '0);
			nop(2);
			go(c_act, b, 13'($urandom), 16'($urandom), '0);
			status("open_bank", 32'h1 << b);
			wr_burst(1'b1);
			wr_burst(1'b0);
			go(c_des, b, {4'h0, col + 9'h1}, 16'($urandom), '0);
			nop(4);
			go(c_rd, b, {2'h0, 1'b1, 1'b0, col}, 16'($urandom), '0);
			for (int k = 0; k <= beats + al; k++) begin
				nop(1);
				if (k > al) begin
					chk("read_oe", 1, oe);
					chk("read_data", exp_mem[k - 1 - al], q);
				end
			end
			nop(1);
			status("auto_pre", 0);
		end
		$display("done: bursts");
		for (int i = 0; i < 4; i++) begin
			go(c_act, 2'(i), 13'($urandom), 16'($urandom), '0);
		end
		status("all_open", 32'hF);
		go(c_act, 2'h3, 13'($urandom), 16'($urandom), '0);
		status("refused", 32'h80F);
		av(1'b1, 5'h00, 32'h2);
		go(c_pre, 2'h0, 13'h0000, 16'($urandom), '0);
		status("disabled", 32'hF);
		av(1'b1, 5'h00, 32'h1);
		go(c_pre, 2'h0, 13'h0000, 16'($urandom), '0);
		nop(1);
		go(c_pre, 2'h0, 13'h0000, 16'($urandom), '0);
		nop(1);
		status("pre_one", 32'hE);
		go(c_rd, 2'h1, 13'h0400, 16'($urandom), '0);
		nop(3);
		go(c_rd, 2'h2, 13'h0000, 16'($urandom), '0);
		nop(4);
		chk("ap_other_oe", 1, oe);
		status("ap_other", 32'hC);
		go(c_pre, 2'h2, 13'h0400, 16'($urandom), '0);
		nop(1);
		status("pre_all", 0);
		$display("done: precharge");
		av(1'b0, 5'h10, '0);
		v = rdata;
		go(c_ref, 2'($urandom), 13'($urandom), 16'($urandom), '0);
		nop(1);
		av(1'b0, 5'h10, '0);
		chk("ref_count", v + 1, rdata);
		go(c_pdn, '0, '0, 16'($urandom), '0);
		av(1'b0, 5'h04, '0);
		chk("pdn_in", 32'h1, rdata[9:8]);
		chk("odt_pdn", 1, odt_on);
		nop(1);
		av(1'b0, 5'h04, '0);
		chk("pdn_out", 0, rdata[9:8]);
		go(c_sre, '0, '0, 16'($urandom), '0);
		repeat (4) @(posedge i_clock);
		chk("sref_in", 1, sref);
		chk("dll_off", 0, dll_on);
		chk("odt_sref", 0, odt_on);
		mdl.idle(1'b1);
		repeat (8) @(posedge i_clock);
		chk("sref_out", 0, sref);
		chk("dll_back", 1, dll_on);
		chk("odt_back", 1, odt_on);
		nop(1);
		$display("done: refresh");
		print_verdict();
	end
endmodule : sdcs_core_bench
